// *** inc/ibp_pkg.sv ***
// constants, types and mode encodings for the inductive button press detector
// assumes a 125 MHz system clock; the i2c and host byte channels sit outside this block
// Operation
// R1 - one i2c master port reaches converter, environment sensor and both haptic drivers
// R2 - clocks come from the crystal source; timer clock is that source divided by eight
// R3 - auxiliary clock goes undivided to the converter reference clock pin
// R4 - after link bring-up: init erm/lra driver, calibrate both, init piezo, load library
// R5 - environment sensor set to 11-bit temperature and humidity resolution
// R6 - converter runs continuous sequential on four channels; 0 down,1 up,2 big,3 little
// R7 - raw samples smoothed by iir average over 16 samples by default
// R8 - baseline updated from instantaneous average, iir length 256 by default
// R9 - press flag when average strictly exceeds baseline plus channel threshold
// R10 - flagged press triggers the actuator and effect assigned to that button
// R11 - baselines start from preset values, not zero
// R12 - timer triggers one environment measurement every second
// R13 - no streaming to host after reset until host requests it
// R14 - host start packet begins streaming
// R15 - host stop notification ends streaming
// R16 - iir: new = (prev*n - prev + sample)/n with n a power of two
// R17 - two-threshold mode adds a higher second threshold with its own effect
// R18 - press-and-release mode fires on press and release; press mode on press only
// R19 - press flag cleared once its effect is dispatched
package ibp_pkg;
    localparam int unsigned IBP_NCH = 4;
    localparam int unsigned IBP_DW = 28;
    localparam int unsigned IBP_CLK_HZ = 125000000;
    localparam int unsigned IBP_XTAL_HZ = 24000000;
    localparam int unsigned IBP_SUB_DIV = 8;
    // environment period in seconds, counted in subsystem clock ticks
    localparam int unsigned IBP_ENV_PERIOD_S = 1;
    localparam int unsigned IBP_ENV_TICKS = IBP_ENV_PERIOD_S * IBP_XTAL_HZ / IBP_SUB_DIV;
    localparam int unsigned IBP_ACC_W = 28;
    localparam logic [3:0] IBP_INST_SH_RST = 4'h4;  // 16 samples
    localparam logic [3:0] IBP_SLOW_SH_RST = 4'h8;  // 256 samples
    localparam logic [3:0] IBP_SH_MAX = 4'h8;
    localparam logic [IBP_DW-1:0] IBP_TH1_RST [IBP_NCH] = '{28'h0001770, 28'h0001770,
        28'h0007530, 28'h0002ee0};
    localparam logic [IBP_DW-1:0] IBP_TH2_RST [IBP_NCH] = '{28'h0019e10, 28'h0019e10,
        28'h001fbd0, 28'h001b580};
    localparam logic [IBP_DW-1:0] IBP_BASE_RST = 28'h0100000;
    localparam logic [7:0] IBP_ENV_RES_11B = 8'h05;
    typedef enum logic [2:0] {
        IBP_CMD_NONE = 3'h0,
        IBP_CMD_ERM_INIT = 3'h1,
        IBP_CMD_CAL_ERM = 3'h2,
        IBP_CMD_CAL_LRA = 3'h3,
        IBP_CMD_PZ_INIT = 3'h4,
        IBP_CMD_PZ_LOAD = 3'h5,
        IBP_CMD_ENV_CFG = 3'h6,
        IBP_CMD_CONV_CFG = 3'h7
    } ibp_cmd_t;
    typedef enum logic [3:0] {
        IBP_S_IDLE = 4'h0,
        IBP_S_ERM_INIT = 4'h1,
        IBP_S_CAL_ERM = 4'h3,
        IBP_S_CAL_LRA = 4'h2,
        IBP_S_PZ_INIT = 4'h6,
        IBP_S_PZ_LOAD = 4'h7,
        IBP_S_ENV_CFG = 4'h5,
        IBP_S_CONV_CFG = 4'h4,
        IBP_S_RUN = 4'hc
    } ibp_state_t;
endpackage

// *** logic/ibp_fifo.sv ***
// stream fifo for the host link, registered read data
// assumes producer and consumer share clk
module ibp_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // space available
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // read data valid
    input wire logic out_ready, // consumer takes data
    output logic [WIDTH-1:0] out_data // read data
);
    localparam int unsigned AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q, rp_q;
    logic full, empty, wr, rd;
    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = (wp_q == rp_q);
    assign in_ready = !full;
    // output register refills when empty or consumed
    assign rd = !empty && (!out_valid || out_ready);
    assign wr = in_valid && !full;
    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (wr) wp_q <= wp_q + 1'b1;
            if (rd) rp_q <= rp_q + 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (rd) begin
            out_valid <= 1'b1;
            out_data <= mem[rp_q[AW-1:0]];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// *** logic/ibp_core.sv ***
// button press detector: bring-up sequencer, iir filters, thresholds, haptic dispatch,
// environment timer and host stream gating
// assumes an outside i2c master executes i2c_cmd words and acks with i2c_done
module ibp_core
    import ibp_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 32,
    parameter int unsigned ENV_TICKS = IBP_ENV_TICKS
) (
    input wire logic clk, // 125 mhz system clock
    input wire logic rstn, // async reset, active low
    input wire logic xtal_clk, // crystal source pin, sampled
    output logic sensor_ref_clock_in, // reference clock to converter
    output logic subsystem_tick, // crystal/8 enable pulse
    input wire logic links_up, // i2c and host links are ready
    output logic i2c_cmd_valid, // i2c master request
    output ibp_cmd_t i2c_cmd, // i2c transaction kind
    output logic [7:0] i2c_cmd_arg, // transaction argument
    input wire logic i2c_done, // i2c master finished request
    output logic init_done, // bring-up complete
    input wire logic sample_valid, // converter sample strobe
    input wire logic [1:0] sample_ch, // sample channel
    input wire logic [IBP_DW-1:0] sample_data, // raw sample
    input wire logic [3:0] inst_shift, // log2 instantaneous length
    input wire logic [3:0] slow_shift, // log2 baseline length
    input wire logic two_thresh, // two-threshold mode
    input wire logic press_only, // fire on press only
    input wire logic [IBP_NCH*IBP_DW-1:0] th1, // first thresholds
    input wire logic [IBP_NCH*IBP_DW-1:0] th2, // second thresholds
    input wire logic [IBP_NCH*8-1:0] effect1, // effect per button, first level
    input wire logic [IBP_NCH*8-1:0] effect2, // effect per button, second level
    input wire logic [IBP_NCH*2-1:0] actuator, // actuator per button
    output logic haptic_valid, // haptic trigger strobe
    output logic [1:0] haptic_actuator, // selected actuator
    output logic [7:0] haptic_effect, // selected effect
    input wire logic haptic_ready, // haptic path accepts
    output logic [IBP_NCH-1:0] press_state, // registered first-threshold press level
    output logic env_measure, // environment measure pulse
    input wire logic host_start, // host start packet
    input wire logic host_stop, // host stop notification
    output logic streaming, // stream active
    output logic stream_valid, // stream word valid
    output logic [31:0] stream_data, // stream word
    input wire logic stream_ready // host takes word
);
    initial begin
        if (FIFO_DEPTH < 2) $error("fifo depth too small");
    end
    // crystal input synchronised, edges counted once stages two and three agree
    logic [2:0] xs_q;
    logic x_lvl_q, x_rise;
    logic [2:0] xdiv_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xs_q <= '0;
            x_lvl_q <= 1'b0;
        end else begin
            xs_q <= {xs_q[1:0], xtal_clk};
            if (xs_q[2] == xs_q[1]) x_lvl_q <= xs_q[2];
        end
    end
    assign x_rise = (xs_q[2] == xs_q[1]) && xs_q[2] && !x_lvl_q;
    // crystal passes undivided; sampled copy would alias at 125 mhz
    assign sensor_ref_clock_in = xtal_clk; // R3
    // divide by eight on crystal edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xdiv_q <= '0;
            subsystem_tick <= 1'b0;
        end else begin
            subsystem_tick <= 1'b0;
            if (x_rise) begin
                xdiv_q <= xdiv_q + 3'h1;
                // eight crystal periods per tick
                subsystem_tick <= (xdiv_q == 3'h7); // R2
            end
        end
    end

    // environment timer
    logic [31:0] env_cnt_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            env_cnt_q <= '0;
            env_measure <= 1'b0;
        end else begin
            env_measure <= 1'b0;
            if (subsystem_tick && init_done) begin
                if (env_cnt_q == ENV_TICKS[31:0] - 32'h1) begin
                    env_cnt_q <= '0;
                    env_measure <= 1'b1; // R12
                end else begin
                    env_cnt_q <= env_cnt_q + 32'h1;
                end
            end
        end
    end

    // bring-up sequencer over the single i2c master
    ibp_state_t st_q;
    logic busy_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= IBP_S_IDLE;
            busy_q <= 1'b0;
        end else begin
            case (st_q)
                IBP_S_IDLE: if (links_up) st_q <= IBP_S_ERM_INIT; // R4
                IBP_S_RUN: st_q <= IBP_S_RUN;
                default: begin
                    if (!busy_q) begin
                        busy_q <= 1'b1;
                    end else if (i2c_done) begin
                        busy_q <= 1'b0;
                        case (st_q)
                            IBP_S_ERM_INIT: st_q <= IBP_S_CAL_ERM;
                            IBP_S_CAL_ERM: st_q <= IBP_S_CAL_LRA;
                            IBP_S_CAL_LRA: st_q <= IBP_S_PZ_INIT;
                            IBP_S_PZ_INIT: st_q <= IBP_S_PZ_LOAD;
                            IBP_S_PZ_LOAD: st_q <= IBP_S_ENV_CFG;
                            IBP_S_ENV_CFG: st_q <= IBP_S_CONV_CFG;
                            IBP_S_CONV_CFG: st_q <= IBP_S_RUN;
                            default: st_q <= IBP_S_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end
    assign init_done = (st_q == IBP_S_RUN);
    always_comb begin
        i2c_cmd_valid = busy_q; // R1
        i2c_cmd_arg = 8'h00;
        case (st_q)
            IBP_S_ERM_INIT: i2c_cmd = IBP_CMD_ERM_INIT;
            IBP_S_CAL_ERM: i2c_cmd = IBP_CMD_CAL_ERM;
            IBP_S_CAL_LRA: i2c_cmd = IBP_CMD_CAL_LRA;
            IBP_S_PZ_INIT: i2c_cmd = IBP_CMD_PZ_INIT;
            IBP_S_PZ_LOAD: i2c_cmd = IBP_CMD_PZ_LOAD;
            IBP_S_ENV_CFG: begin
                i2c_cmd = IBP_CMD_ENV_CFG;
                i2c_cmd_arg = IBP_ENV_RES_11B; // R5
            end
            IBP_S_CONV_CFG: begin
                i2c_cmd = IBP_CMD_CONV_CFG;
                i2c_cmd_arg = 8'h0f; // R6
            end
            default: i2c_cmd = IBP_CMD_NONE;
        endcase
    end

    // per-channel filters and detection
    logic [IBP_NCH-1:0] lvl1, lvl2, fire1, fire_rel, fire2;
    logic [IBP_NCH-1:0] pend1_q, pend2_q, prel_q, hi_q;
    logic [3:0] ish, ssh;
    assign ish = (inst_shift > IBP_SH_MAX) ? IBP_SH_MAX : inst_shift;
    assign ssh = (slow_shift > IBP_SH_MAX) ? IBP_SH_MAX : slow_shift;
    genvar g;
    generate
        for (g = 0; g < IBP_NCH; g++) begin : g_ch
            logic [IBP_DW-1:0] inst_q, base_q, t1, t2;
            logic [IBP_DW+8:0] inst_nx, base_nx;
            logic hit;
            assign t1 = th1[g*IBP_DW +: IBP_DW];
            assign t2 = th2[g*IBP_DW +: IBP_DW];
            assign hit = sample_valid && init_done && (sample_ch == 2'(g)); // R6
            // (prev*n - prev + x)/n using shifts only
            assign inst_nx = (({9'h0, inst_q} << ish) - {9'h0, inst_q}
                + {9'h0, sample_data}) >> ish; // R7 R16
            assign base_nx = (({9'h0, base_q} << ssh) - {9'h0, base_q}
                + {9'h0, inst_nx[IBP_DW-1:0]}) >> ssh; // R8 R16
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    inst_q <= IBP_BASE_RST;
                    base_q <= IBP_BASE_RST; // R11
                end else if (hit) begin
                    inst_q <= inst_nx[IBP_DW-1:0];
                    base_q <= base_nx[IBP_DW-1:0];
                end
            end
            // sums kept one bit wider so large thresholds cannot wrap
            assign lvl1[g] = {1'b0, inst_q} > ({1'b0, base_q} + {1'b0, t1}); // R9
            // second level ignored unless above the first
            assign lvl2[g] = two_thresh && (t2 > t1)
                && ({1'b0, inst_q} > ({1'b0, base_q} + {1'b0, t2})); // R17
        end
    endgenerate

    logic [IBP_NCH-1:0] press_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            press_q <= '0;
            hi_q <= '0;
        end else begin
            press_q <= lvl1;
            hi_q <= lvl2;
        end
    end
    assign press_state = press_q;
    assign fire1 = lvl1 & ~press_q;
    assign fire2 = lvl2 & ~hi_q;
    assign fire_rel = ~lvl1 & press_q & {IBP_NCH{!press_only}}; // R18

    // pending flags: set wins over the dispatch clear
    logic [1:0] sel;
    logic sel_any, sel_l2, sel_rel;
    always_comb begin
        sel = 2'h0;
        sel_any = 1'b0;
        sel_l2 = 1'b0;
        sel_rel = 1'b0;
        for (int i = IBP_NCH - 1; i >= 0; i--) begin
            if (pend1_q[i] || pend2_q[i] || prel_q[i]) begin
                sel = 2'(i);
                sel_any = 1'b1;
                sel_l2 = pend2_q[i];
                sel_rel = !pend2_q[i] && !pend1_q[i];
            end
        end
    end
    logic take;
    assign take = sel_any && (!haptic_valid || haptic_ready);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend1_q <= '0;
            pend2_q <= '0;
            prel_q <= '0;
        end else begin
            for (int i = 0; i < IBP_NCH; i++) begin
                if (take && sel == 2'(i)) begin
                    if (sel_l2) pend2_q[i] <= 1'b0; // R19
                    else if (sel_rel) prel_q[i] <= 1'b0; // R19
                    else pend1_q[i] <= 1'b0; // R19
                end
                if (fire1[i]) pend1_q[i] <= 1'b1;
                if (fire2[i]) pend2_q[i] <= 1'b1;
                if (fire_rel[i]) prel_q[i] <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            haptic_valid <= 1'b0;
            haptic_actuator <= 2'h0;
            haptic_effect <= 8'h00;
        end else if (take) begin
            haptic_valid <= 1'b1; // R10
            haptic_actuator <= actuator[sel*2 +: 2];
            haptic_effect <= sel_l2 ? effect2[sel*8 +: 8] : effect1[sel*8 +: 8]; // R17
        end else if (haptic_ready) begin
            haptic_valid <= 1'b0;
        end
    end

    // host stream gating; a start together with stop keeps the stop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            streaming <= 1'b0; // R13
        end else if (host_stop) begin
            streaming <= 1'b0; // R15
        end else if (host_start) begin
            streaming <= 1'b1; // R14
        end
    end
    logic f_in_ready;
    logic [31:0] f_word;
    assign f_word = {press_q, sample_ch, 2'h0, sample_data[23:0]};
    ibp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(sample_valid && streaming && init_done),
        .in_ready(f_in_ready),
        .in_data(f_word),
        .out_valid(stream_valid),
        .out_ready(stream_ready && streaming),
        .out_data(stream_data)
    );
    // overflow count; converter cannot be stalled, so full drops samples
    logic [15:0] drop_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) drop_q <= '0;
        else if (sample_valid && streaming && !f_in_ready) drop_q <= drop_q + 16'h1;
    end
endmodule

// *** verif/ibp_partner.sv ***
// far-side model: i2c master executor, haptic drivers and host reader
// assumes one clock with the core; stall slows the haptic answers and holds off the host reader, not the i2c done
module ibp_partner
    import ibp_pkg::*;
#(
    parameter int unsigned DLY = 3
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic cmd_valid, // request from the core
    input wire logic [2:0] cmd, // request kind
    output logic done, // request finished
    input wire logic stall, // slow answers
    output logic hap_ready, // haptic drivers accept
    output logic host_ready // host takes words
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic [2:0] log_q [8];
    logic [3:0] n_q;
    logic slow;
    // calibration takes long on real actuators, so those steps answer late
    assign slow = (cmd == IBP_CMD_CAL_ERM) || (cmd == IBP_CMD_CAL_LRA);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 8'h0;
            done <= 1'b0;
            n_q <= 4'h0;
        end else if (cmd_valid && !done && cnt_q >= (slow ? 8'(4 * DLY) : 8'(DLY))) begin
            done <= 1'b1;
            cnt_q <= 8'h0;
            log_q[n_q[2:0]] <= cmd;
            n_q <= n_q + 4'h1;
        end else begin
            done <= 1'b0;
            cnt_q <= (cmd_valid && !done) ? cnt_q + 8'h1 : 8'h0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hap_ready <= 1'b0;
            host_ready <= 1'b0;
        end else begin
            hap_ready <= stall ? !hap_ready : 1'b1;
            host_ready <= !stall;
        end
    end
endmodule

// *** verif/ibp_core_chk.sv ***
// port assertions for the detector core
// assumes ibp_pkg; bound onto every ibp_core at the foot
module ibp_core_chk
    import ibp_pkg::*;
#(
    parameter int unsigned ENV_TICKS = 10
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset
    input wire logic xtal_clk, // crystal pin
    input wire logic sensor_ref_clock_in, // converter clock
    input wire logic subsystem_tick, // divided tick
    input wire logic i2c_cmd_valid, // i2c request
    input wire ibp_cmd_t i2c_cmd, // i2c kind
    input wire logic [7:0] i2c_cmd_arg, // i2c argument
    input wire logic i2c_done, // i2c ack
    input wire logic init_done, // bring-up over
    input wire logic env_measure, // env pulse
    input wire logic host_start, // start packet
    input wire logic host_stop, // stop packet
    input wire logic streaming, // stream on
    input wire logic stream_valid, // stream word
    input wire logic [31:0] stream_data, // stream data
    input wire logic stream_ready, // host takes
    input wire logic haptic_valid, // haptic strobe
    input wire logic [1:0] haptic_actuator, // actuator
    input wire logic [7:0] haptic_effect, // effect
    input wire logic haptic_ready // haptic accepts
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ibp_cmd_t exp_q;
    logic ever_q, env_seen_q;
    logic [31:0] ticks_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) exp_q <= IBP_CMD_ERM_INIT;
        else if (i2c_cmd_valid && i2c_done) exp_q <= ibp_cmd_t'(i2c_cmd + 3'h1);
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) ever_q <= 1'b0;
        else if (streaming) ever_q <= 1'b1;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ticks_q <= 32'h0;
            env_seen_q <= 1'b0;
        end else if (env_measure) begin
            ticks_q <= 32'(subsystem_tick);
            env_seen_q <= 1'b1;
        end else begin
            ticks_q <= ticks_q + 32'(subsystem_tick);
        end
    end
    AST_REF_FOLLOW: assert property (sensor_ref_clock_in == xtal_clk)
        else $error("ref clock wrong");
    AST_SUB_GAP: assert property (subsystem_tick |=> (!subsystem_tick) [*8])
        else $error("ticks too close");
    AST_CMD_HOLD: assert property (i2c_cmd_valid && !i2c_done |=> i2c_cmd_valid && $stable(i2c_cmd))
        else $error("i2c request dropped");
    AST_CMD_ORDER: assert property ($rose(i2c_cmd_valid) |-> i2c_cmd == exp_q)
        else $error("bring-up order wrong");
    AST_ENV_ARG: assert property (i2c_cmd_valid && i2c_cmd == IBP_CMD_ENV_CFG |-> i2c_cmd_arg == 8'h05)
        else $error("env argument wrong");
    AST_CONV_ARG: assert property (i2c_cmd_valid && i2c_cmd == IBP_CMD_CONV_CFG |-> i2c_cmd_arg == 8'h0f)
        else $error("conv argument wrong");
    AST_RUN_QUIET: assert property (init_done |-> !i2c_cmd_valid)
        else $error("i2c request after bring-up");
    AST_ENV_PERIOD: assert property (env_measure && env_seen_q |-> ticks_q >= ENV_TICKS - 1 && ticks_q <= ENV_TICKS + 1 ##1 !env_measure)
        else $error("env period wrong");
    AST_NO_EARLY_STREAM: assert property (!ever_q |-> !stream_valid)
        else $error("stream word before start");
    AST_START: assert property (host_start && !host_stop |=> streaming)
        else $error("start ignored");
    AST_STOP: assert property (host_stop |=> !streaming)
        else $error("stop ignored");
    AST_HAPTIC_HOLD: assert property (haptic_valid && !haptic_ready |=> haptic_valid && $stable({haptic_actuator, haptic_effect}))
        else $error("haptic request changed");
    AST_STREAM_HOLD: assert property (stream_valid && !stream_ready |=> stream_valid && $stable(stream_data))
        else $error("stream word changed");
endmodule
bind ibp_core ibp_core_chk #(.ENV_TICKS(ENV_TICKS)) ibp_core_chk_i (.clk, .rstn, .xtal_clk,
    .sensor_ref_clock_in, .subsystem_tick, .i2c_cmd_valid, .i2c_cmd, .i2c_cmd_arg, .i2c_done,
    .init_done, .env_measure, .host_start, .host_stop, .streaming, .stream_valid, .stream_data,
    .stream_ready, .haptic_valid, .haptic_actuator, .haptic_effect, .haptic_ready);

// *** verif/ibp_core_bench.sv ***
// self-checking bench for the detector core: bring-up, press table, modes, stream
// assumes ibp_pkg, ibp_fifo, ibp_core, ibp_partner and the bound checker
module ibp_core_bench
    import ibp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [3:0] sh; logic [1:0] ch; logic [27:0] d; logic [3:0] p;} ibp_row_t;
    localparam logic [27:0] BASE = IBP_BASE_RST;
    // shift 0 makes the average equal the sample, so margins stay wide
    localparam ibp_row_t ROWS [9] = '{'{4'h4, 2'h0, 28'h0110000, 4'h0},
        '{4'h4, 2'h0, 28'h0110000, 4'h1}, '{4'h0, 2'h1, 28'h0101000, 4'h1},
        '{4'h0, 2'h1, 28'h0102000, 4'h3}, '{4'h0, 2'h0, 28'h0100000, 4'h2},
        '{4'h0, 2'h3, 28'h0104000, 4'ha}, '{4'h0, 2'h2, 28'h0104000, 4'ha},
        '{4'h0, 2'h1, 28'h0100000, 4'h8}, '{4'h0, 2'h3, 28'h0100000, 4'h0}};
    logic clk = 1'b0, rstn = 1'b0, xtal = 1'b0, links_up = 1'b0, sv = 1'b0, two = 1'b0;
    logic ponly = 1'b0, hstart = 1'b0, hstop = 1'b0, stall = 1'b0;
    logic [1:0] sch = 2'h0;
    logic [27:0] sdat = 28'h0;
    logic [3:0] ish = 4'h4, ssh = 4'h8, press;
    logic [111:0] th1 = {IBP_TH1_RST[3], IBP_TH1_RST[2], IBP_TH1_RST[1], IBP_TH1_RST[0]};
    logic [111:0] th2 = {IBP_TH2_RST[3], IBP_TH2_RST[2], IBP_TH2_RST[1], IBP_TH2_RST[0]};
    logic [31:0] eff1 = 32'h44332211, eff2 = 32'h88776655, sdata;
    logic [7:0] act = 8'he4, carg, heff;
    logic ref_clk, sub_tick, cmd_v, cmd_done, init_done, hv, hr, sr, env, streaming, stv;
    logic [1:0] hact;
    ibp_cmd_t cmd;
    logic [9:0] hq [$];
    logic [31:0] wq [$];
    int err_total = 0, n_compared = 0, nenv = 0, ntick = 0;
    ibp_core #(.ENV_TICKS(10)) ibp_core_i (.clk(clk), .rstn(rstn), .xtal_clk(xtal),
        .sensor_ref_clock_in(ref_clk), .subsystem_tick(sub_tick), .links_up(links_up),
        .i2c_cmd_valid(cmd_v), .i2c_cmd(cmd), .i2c_cmd_arg(carg), .i2c_done(cmd_done),
        .init_done(init_done), .sample_valid(sv), .sample_ch(sch), .sample_data(sdat),
        .inst_shift(ish), .slow_shift(ssh), .two_thresh(two), .press_only(ponly), .th1(th1),
        .th2(th2), .effect1(eff1), .effect2(eff2), .actuator(act), .haptic_valid(hv),
        .haptic_actuator(hact), .haptic_effect(heff), .haptic_ready(hr), .press_state(press),
        .env_measure(env), .host_start(hstart), .host_stop(hstop), .streaming(streaming),
        .stream_valid(stv), .stream_data(sdata), .stream_ready(sr));
    ibp_partner #(.DLY(3)) ibp_partner_i (.clk(clk), .rstn(rstn), .cmd_valid(cmd_v), .cmd(cmd),
        .done(cmd_done), .stall(stall), .hap_ready(hr), .host_ready(sr));
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        forever #20.833 xtal = ~xtal;
    end
    always @(posedge clk) begin
        if (hv && hr) hq.push_back({hact, heff});
        if (stv && sr) wq.push_back(sdata);
        if (env) nenv++;
        if (sub_tick) ntick++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic sample(input logic [1:0] ch, input logic [27:0] d);
        @(posedge clk);
        sch <= ch;
        sdat <= d;
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic pulse_host(input logic st, input logic sp);
        @(posedge clk);
        hstart <= st;
        hstop <= sp;
        @(posedge clk);
        hstart <= 1'b0;
        hstop <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        #400000;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        check(32'({cmd_v, init_done, hv, streaming, stv, env, press}), 32'h0);
        rstn <= 1'b1;
        repeat (20) @(posedge clk);
        check(32'(cmd_v), 32'h0);
        links_up <= 1'b1;
        for (int i = 0; i < 500 && init_done !== 1'b1; i++) @(posedge clk);
        check(32'(init_done), 32'h1);
        check(32'(ibp_partner_i.n_q), 32'h7);
        for (int k = 0; k < 7; k++) check(32'(ibp_partner_i.log_q[k]), 32'(k + 1));
        foreach (ROWS[i]) begin
            ish <= ROWS[i].sh;
            sample(ROWS[i].ch, ROWS[i].d);
            check(32'(press), 32'(ROWS[i].p));
        end
        check(32'(hq.size()), 32'h6);
        check(32'(hq[0]), 32'h011);
        check(32'(hq[1]), 32'h122);
        check(32'(hq[3]), 32'h344);
        hq.delete();
        ponly <= 1'b1;
        sample(2'h2, BASE + 28'h10000);
        check(32'(press), 32'h4);
        sample(2'h2, BASE);
        check(32'(hq.size()), 32'h1);
        check(32'(hq[0]), 32'h233);
        hq.delete();
        ponly <= 1'b0;
        two <= 1'b1;
        sample(2'h0, BASE + 28'h20000);
        check(32'(hq[0]), 32'h055);
        sample(2'h0, BASE);
        check(32'(wq.size()), 32'h0);
        pulse_host(1'b1, 1'b0);
        check(32'(streaming), 32'h1);
        stall <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            sch <= 2'h2;
            sdat <= BASE + 28'(i);
            sv <= 1'b1;
            @(posedge clk);
        end
        sv <= 1'b0;
        repeat (10) @(posedge clk);
        check(32'({stv, 6'(wq.size())}), 32'h40);
        stall <= 1'b0;
        repeat (80) @(posedge clk);
        check(32'(wq.size() inside {[32:34]}), 32'h1);
        check(32'(wq[0][27:0]), 32'h8100000);
        wq.delete();
        pulse_host(1'b1, 1'b1);
        check(32'(streaming), 32'h0);
        sample(2'h1, BASE);
        check(32'(wq.size()), 32'h0);
        ntick = 0;
        nenv = 0;
        repeat (1250) @(posedge clk);
        check(32'(ntick inside {[29:31]}), 32'h1);
        check(32'(nenv inside {[2:4]}), 32'h1);
        pulse_host(1'b1, 1'b0);
        rstn <= 1'b0;
        @(posedge clk);
        check(32'({streaming, init_done, press}), 32'h0);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        check(32'(streaming), 32'h0);
        print_verdict();
    end
endmodule
